// ---- hw/acc_ctrl.sv ----
`timescale 1ns/1ps
`include "acc_map.svh"

module acc_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire acc_pkg::acc_bus_t bus,
    output logic [31:0] rd_data,
    // host pins
    input wire acc_pkg::acc_pins_t pins,
    // device outputs
    output logic result_ready_n,
    output logic irq
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [3:0] sync1_reg; // first stage, read only by sync2
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;
    logic [3:0] filt_reg; // accepted pin level
    logic [3:0] filt_d_reg; // previous accepted level

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 4'h4;
            sync2_reg <= 4'h4;
            sync3_reg <= 4'h4;
            filt_reg <= 4'h4;
            filt_d_reg <= 4'h4;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
            filt_d_reg <= filt_reg;
        end
    end

    logic pin_rise; // start pin went high
    logic pin_fall; // start pin went low
    logic sclk_fall; // serial clock falling edge
    logic cs_act; // frame selected
    logic sdi_f; // filtered serial data

    assign pin_rise = filt_reg[0] & ~filt_d_reg[0];
    assign pin_fall = ~filt_reg[0] & filt_d_reg[0];
    assign sclk_fall = ~filt_reg[1] & filt_d_reg[1];
    assign cs_act = ~filt_reg[2];
    assign sdi_f = filt_reg[3];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] mode_config_first_reg; // filter and conversion mode
    logic [23:0] period_reg; // conversion period, microseconds
    logic [15:0] delay_reg; // start delay, microseconds
    logic [1:0] ctrl_reg; // crc and chop enables
    logic [2:0] int_stat_reg; // sticky events
    logic [2:0] int_mask_reg; // event enables
    logic conversion_mode_select; // 1 = pulse, 0 = continuous

    assign conversion_mode_select = mode_config_first_reg[`ACC_MODE_CONV_BIT];

    // software writes to configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_config_first_reg <= `ACC_MODE_RST;
            period_reg <= `ACC_PERIOD_RST;
            delay_reg <= `ACC_START_DELAY_US;
            ctrl_reg <= `ACC_CTRL_RST;
            int_mask_reg <= 3'h0;
        end else if (bus.wr) begin
            if (bus.addr == `ACC_OFS_MODE) begin
                mode_config_first_reg <= bus.wdata[7:0];
            end else if (bus.addr == `ACC_OFS_PERIOD) begin
                period_reg <= bus.wdata[23:0];
            end else if (bus.addr == `ACC_OFS_DELAY) begin
                delay_reg <= bus.wdata[15:0];
            end else if (bus.addr == `ACC_OFS_CTRL) begin
                ctrl_reg <= bus.wdata[1:0];
            end else if (bus.addr == `ACC_OFS_INT_MASK) begin
                int_mask_reg <= bus.wdata[2:0];
            end
        end
    end

    // ----------------------------------------
    // microsecond tick
    // ----------------------------------------
    logic [7:0] pre_reg; // prescaler count
    logic tick_reg; // one-cycle pulse per microsecond

    // timers count microseconds so long periods need narrow-ish counters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else if (pre_reg == 8'(`ACC_TICK_CYC - 1)) begin
            pre_reg <= 8'h00;
            tick_reg <= 1'b1;
        end else begin
            pre_reg <= pre_reg + 8'h01;
            tick_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // serial command capture
    // ----------------------------------------
    logic [5:0] edge_cnt_reg; // falling edges in this frame
    logic [7:0] opcode_reg; // first byte of the frame
    logic [5:0] edges_need; // edge that applies the command
    logic cmd_apply; // command takes effect now
    logic cmd_start;
    logic cmd_stop;

    assign edges_need = ctrl_reg[`ACC_CTRL_CRC_BIT] ? `ACC_EDGES_CRC : `ACC_EDGES_PLAIN;
    assign cmd_apply = sclk_fall & cs_act & (edge_cnt_reg + 6'h01 == edges_need);
    assign cmd_start = cmd_apply & (opcode_reg == `ACC_OP_START);
    assign cmd_stop = cmd_apply & (opcode_reg == `ACC_OP_STOP);

    // count falling edges; opcode shifts in msb first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt_reg <= 6'h00;
            opcode_reg <= 8'h00;
        end else if (!cs_act) begin
            edge_cnt_reg <= 6'h00;
        end else if (sclk_fall) begin
            // saturate so a long frame never re-applies
            if (edge_cnt_reg != 6'h3F) begin
                edge_cnt_reg <= edge_cnt_reg + 6'h01;
            end
            if (edge_cnt_reg < 6'h08) begin
                opcode_reg <= {opcode_reg[6:0], sdi_f};
            end
        end
    end

    // ----------------------------------------
    // start and stop events
    // ----------------------------------------
    logic start_evt; // begin or restart
    logic stop_evt; // stop request

    // either method may be used; the host keeps the pin low for commands
    assign start_evt = pin_rise | cmd_start;
    assign stop_evt = pin_fall | cmd_stop;

    // ----------------------------------------
    // conversion sequencer
    // ----------------------------------------
    acc_pkg::acc_state_t state_reg;
    logic [15:0] dly_cnt_reg; // start delay remaining
    logic [31:0] conv_cnt_reg; // conversion time remaining
    logic run_reg; // continuous run requested
    logic conv_done; // result ready this cycle
    logic dly_done; // delay over this cycle
    logic [31:0] first_len; // first conversion length

    // first result needs order periods plus overhead, doubled under chop
    function automatic logic [31:0] first_time(input logic [2:0] filt, input logic chop,
                                               input logic [23:0] per, input logic [15:0] dly);
        logic [3:0] mult;
        mult = 4'h1;
        // fir (4) and sinc1 (0) settle in one period
        if (filt < 3'h4) begin
            mult = {1'b0, filt} + 4'h1;
        end else if (filt > 3'h4) begin
            mult = 4'h5;
        end
        first_time = 32'(per) * 32'(mult) + 32'(`ACC_PROC_US);
        // chop withholds a whole first conversion, delay and overhead included
        if (chop) begin
            first_time = {first_time[30:0], 1'b0} + 32'(dly);
        end
    endfunction : first_time

    assign first_len = first_time(mode_config_first_reg[2:0], ctrl_reg[`ACC_CTRL_CHOP_BIT],
                                  period_reg, delay_reg);
    assign dly_done = (state_reg == acc_pkg::ST_DELAY) & tick_reg & (dly_cnt_reg <= 16'h0001);
    assign conv_done = (state_reg == acc_pkg::ST_CONV) & tick_reg & (conv_cnt_reg <= 32'h1)
                       & ~start_evt;

    // run flag: a start sets it over a simultaneous stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_reg <= 1'b0;
        end else if (start_evt) begin
            run_reg <= 1'b1;
        end else if (stop_evt) begin
            run_reg <= 1'b0;
        end
    end

    // state, delay and conversion timers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= acc_pkg::ST_IDLE;
            dly_cnt_reg <= 16'h0000;
            conv_cnt_reg <= 32'h0;
        end else if (start_evt) begin
            // abandon any partial result and time from the new start
            state_reg <= acc_pkg::ST_DELAY;
            dly_cnt_reg <= delay_reg;
        end else begin
            case (state_reg)
                acc_pkg::ST_DELAY: begin
                    if (dly_done) begin
                        state_reg <= acc_pkg::ST_CONV;
                        conv_cnt_reg <= first_len;
                    end else if (tick_reg) begin
                        dly_cnt_reg <= dly_cnt_reg - 16'h0001;
                    end
                end
                acc_pkg::ST_CONV: begin
                    // a stop never cuts the running conversion short
                    if (conv_done) begin
                        if (conversion_mode_select || !run_reg) begin
                            state_reg <= acc_pkg::ST_IDLE;
                        end else begin
                            conv_cnt_reg <= 32'(period_reg);
                        end
                    end else if (tick_reg) begin
                        conv_cnt_reg <= conv_cnt_reg - 32'h1;
                    end
                end
                default: begin
                    state_reg <= acc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // ready output
    // ----------------------------------------
    logic [23:0] hold_cnt_reg; // low time before next conversion shows

    // low with each result; in continuous runs it rises again after a
    // short hold so the host sees a falling edge per result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_ready_n <= 1'b1;
            hold_cnt_reg <= 24'h0;
        end else if (start_evt) begin
            result_ready_n <= 1'b1;
            hold_cnt_reg <= 24'h0;
        end else if (conv_done) begin
            result_ready_n <= 1'b0;
            hold_cnt_reg <= (conversion_mode_select || !run_reg) ? 24'h0 : `ACC_RDY_HOLD_US;
        end else if (tick_reg && hold_cnt_reg != 24'h0) begin
            hold_cnt_reg <= hold_cnt_reg - 24'h1;
            if (hold_cnt_reg == 24'h1) begin
                result_ready_n <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    logic [2:0] int_evt; // events this cycle
    logic [2:0] int_clr; // write-one-to-clear

    assign int_evt = {cmd_apply, start_evt & (state_reg != acc_pkg::ST_IDLE), conv_done};
    assign int_clr = (bus.wr && bus.addr == `ACC_OFS_INT_STAT) ? bus.wdata[2:0] : 3'h0;

    // hardware set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stat_reg <= 3'h0;
        end else begin
            int_stat_reg <= (int_stat_reg & ~int_clr) | int_evt;
        end
    end

    // level output, one cycle behind the sticky bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 32'h0;
        end else if (!bus.rd) begin
            rd_data <= 32'h0;
        end else if (bus.addr == `ACC_OFS_MODE) begin
            rd_data <= {24'h0, mode_config_first_reg};
        end else if (bus.addr == `ACC_OFS_PERIOD) begin
            rd_data <= {8'h0, period_reg};
        end else if (bus.addr == `ACC_OFS_DELAY) begin
            rd_data <= {16'h0, delay_reg};
        end else if (bus.addr == `ACC_OFS_CTRL) begin
            rd_data <= {30'h0, ctrl_reg};
        end else if (bus.addr == `ACC_OFS_STATUS) begin
            rd_data <= {27'h0, result_ready_n, run_reg, 1'b0, state_reg};
        end else if (bus.addr == `ACC_OFS_INT_STAT) begin
            rd_data <= {29'h0, int_stat_reg};
        end else if (bus.addr == `ACC_OFS_INT_MASK) begin
            rd_data <= {29'h0, int_mask_reg};
        end else begin
            rd_data <= 32'h0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_delay_end;
        (state_reg == acc_pkg::ST_DELAY) && tick_reg && (dly_cnt_reg <= 16'h0001) && !start_evt;
    endsequence

    sequence s_result;
        conv_done;
    endsequence

    a_cmd_edge_count: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_apply |-> sclk_fall && (edge_cnt_reg == edges_need - 6'h01))
        else $error("command applied on wrong edge");

    a_pin_start: assert property (@(posedge clk) disable iff (!rst_n)
        pin_rise |=> (state_reg == acc_pkg::ST_DELAY) && result_ready_n)
        else $error("pin rise did not start");

    a_restart_drops: assert property (@(posedge clk) disable iff (!rst_n)
        (start_evt && state_reg == acc_pkg::ST_CONV) |=> (state_reg == acc_pkg::ST_DELAY)
        && (dly_cnt_reg == $past(delay_reg)) && result_ready_n)
        else $error("restart did not abandon conversion");

    a_ready_low_result: assert property (@(posedge clk) disable iff (!rst_n)
        s_result |=> !result_ready_n)
        else $error("ready not low after result");

    a_first_length: assert property (@(posedge clk) disable iff (!rst_n)
        (s_delay_end and (mode_config_first_reg[1:0] == 2'h0)) |=> (state_reg == acc_pkg::ST_CONV)
        && (conv_cnt_reg == ($past(ctrl_reg[`ACC_CTRL_CHOP_BIT]) ? 32'($past(delay_reg))
        + (32'($past(period_reg)) + 32'(`ACC_PROC_US)) * 32'h2 : 32'($past(period_reg)) + 32'(`ACC_PROC_US))))
        else $error("first conversion length wrong");

    a_pulse_single: assert property (@(posedge clk) disable iff (!rst_n)
        (s_result and conversion_mode_select) |=> (state_reg == acc_pkg::ST_IDLE))
        else $error("pulse mode kept converting");

    a_cont_period: assert property (@(posedge clk) disable iff (!rst_n)
        (s_result and (!conversion_mode_select && run_reg))
        |=> (state_reg == acc_pkg::ST_CONV) && (conv_cnt_reg == 32'($past(period_reg))))
        else $error("continuous period wrong");

    a_stop_no_cut: assert property (@(posedge clk) disable iff (!rst_n)
        (stop_evt && !start_evt && state_reg == acc_pkg::ST_CONV && !conv_done)
        |=> (state_reg == acc_pkg::ST_CONV))
        else $error("stop cut a conversion short");

endmodule : acc_ctrl

// ---- hw/acc_map.svh ----
// What this block does
// - start pin or serial command starts conversions
// - commands act on 16th/32nd falling clock edge
// - mode bit 4 picks continuous or pulse
// - continuous mode converts until stop request
// - ready high at start, low with result
// - continuous stop lets running conversion finish
// - pin low-high or new start restarts
// - pulse mode makes exactly one conversion
// - pulse conversion survives pin low or stop
// - fir and sinc1 settle in one period
// - first latency includes delay plus overhead
// - later continuous results one period apart
// - chop doubles the first conversion latency
// - programmable start delay, default fifty microseconds
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ----------------------------------------
// register offsets (word index)
// ----------------------------------------
`define ACC_OFS_MODE 4'h0
`define ACC_OFS_PERIOD 4'h1
`define ACC_OFS_DELAY 4'h2
`define ACC_OFS_CTRL 4'h3
`define ACC_OFS_STATUS 4'h4
`define ACC_OFS_INT_STAT 4'h5
`define ACC_OFS_INT_MASK 4'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define ACC_MODE_CONV_BIT 4
`define ACC_CTRL_CRC_BIT 0
`define ACC_CTRL_CHOP_BIT 1
`define ACC_INT_READY_BIT 0
`define ACC_INT_RESTART_BIT 1
`define ACC_INT_CMD_BIT 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACC_MODE_RST 8'h00
`define ACC_PERIOD_RST 24'h00C350
`define ACC_CTRL_RST 2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define ACC_CLK_NS 10
`define ACC_US_NS 1000
`define ACC_TICK_CYC (`ACC_US_NS / `ACC_CLK_NS)
`define ACC_START_DELAY_US 16'h0032
`define ACC_PROC_US 24'h00017C
`define ACC_RDY_HOLD_US 24'h000008
`define ACC_EDGES_PLAIN 6'h10
`define ACC_EDGES_CRC 6'h20

// ----------------------------------------
// command opcodes (values arbitrary)
// ----------------------------------------
`define ACC_OP_START 8'hA5
`define ACC_OP_STOP 8'h5A

`endif

// ---- hw/acc_pkg.sv ----
package acc_pkg;
    // conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV = 2'b10
    } acc_state_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } acc_bus_t;

    // pins from the host, outside the clock domain
    typedef struct packed {
        logic sdi;
        logic cs_n;
        logic sclk;
        logic start;
    } acc_pins_t;
endpackage : acc_pkg

// ---- test/acc_host_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// host side: start pin and framed serial commands
// ----------------------------------------
module acc_host_model (
    // clock used only to align pin changes
    input wire logic clk,
    // pins toward the converter
    output acc_pkg::acc_pins_t pins
);
    // idle frame, serial clock parked low
    initial begin
        pins = '{sdi: 1'b0, cs_n: 1'b1, sclk: 1'b0, start: 1'b0};
    end

    // start pin level, changed just after a clock edge
    task automatic set_start(input logic level);
        @(posedge clk);
        pins.start <= level;
    endtask : set_start

    // one framed command; fewer edges than needed aborts it
    task automatic send_cmd(input logic [7:0] op, input int edges);
        logic [23:0] tail;
        tail = 24'($urandom);
        @(posedge clk);
        pins.start <= 1'b0;
        pins.cs_n <= 1'b0;
        for (int i = 0; i < edges; i++) begin
            // opcode first, msb leading; the rest is filler
            // data moves with the rising edge so it stands through the fall
            repeat (4) @(posedge clk);
            pins.sclk <= 1'b1;
            pins.sdi <= (i < 8) ? op[7 - i] : tail[i % 24];
            repeat (4) @(posedge clk);
            pins.sclk <= 1'b0;
        end
        // leave time for the edge filter before closing the frame
        repeat (8) @(posedge clk);
        pins.cs_n <= 1'b1;
        // released line must not keep showing the last bit
        pins.sdi <= ~pins.sdi;
    endtask : send_cmd
endmodule : acc_host_model

// ---- test/adc_conversion_control_tb.sv ----
`timescale 1ns/1ps
`include "acc_map.svh"

module adc_conversion_control_tb;
    // ----------------------------------------
    // signals and scoreboard
    // ----------------------------------------
    logic clk;
    logic rst_n;
    acc_pkg::acc_bus_t bus; // register requests
    logic [31:0] rd_data;
    acc_pkg::acc_pins_t pins; // driven by the host model
    logic result_ready_n;
    logic irq;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0; // free clock count, also the hang guard
    int period_us; // random conversion period
    int delay_us = 3; // short start delay keeps the run small
    int t0;
    int n;
    logic [31:0] rv;
    int exp_q[$]; // expected latencies, oldest first
    logic [31:0] rst_tab [8] = '{32'h0, 32'h0000_C350, 32'h0000_0032, 32'h0, 32'h0000_0010, 32'h0, 32'h0, 32'h0};

    // ----------------------------------------
    // instances
    // ----------------------------------------
    acc_ctrl u_dut (
        .clk(clk),
        .rst_n(rst_n),
        .bus(bus),
        .rd_data(rd_data),
        .pins(pins),
        .result_ready_n(result_ready_n),
        .irq(irq)
    );

    acc_host_model u_host (
        .clk(clk),
        .pins(pins)
    );

    // ----------------------------------------
    // clock, hang guard, verdict
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // two long conversions dominate; the ceiling leaves some slack
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------
    // bus cycles and comparisons
    // ----------------------------------------
    task automatic reg_wr(input logic [3:0] addr, input logic [31:0] data);
        @(posedge clk);
        bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] addr, output logic [31:0] data);
        @(posedge clk);
        bus <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        data = rd_data;
    endtask : reg_rd

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // timing has a microsecond tick of jitter plus pin filtering
    task automatic check_near(input int got, input int tol);
        int exp;
        exp = exp_q.pop_front();
        comparisons++;
        if (got < exp - tol || got > exp + tol) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_near

    task automatic wait_ready(input logic level, input int limit);
        n = 0;
        while (result_ready_n !== level && n < limit) begin
            @(posedge clk);
            n++;
        end
        // a wait that runs out is a failure of its own
        if (result_ready_n !== level) begin
            fail_count++;
        end
    endtask : wait_ready

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        bus = '0;
        rst_n = 1'b0;
        void'($urandom(32'hB161));
        period_us = 10 + int'($urandom % 8);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;

        // reset values, unmapped place reads zero
        for (int a = 0; a < 8; a++) begin
            reg_rd(4'(a), rv);
            check(rv, rst_tab[a]);
        end
        @(posedge clk);
        #1;
        check(rd_data, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test reset values done");

        // framing: aborted frame, short frame under crc, full frame
        reg_wr(`ACC_OFS_PERIOD, 32'(period_us));
        reg_wr(`ACC_OFS_DELAY, 32'(delay_us));
        reg_wr(`ACC_OFS_INT_MASK, 32'h0000_0001);
        u_host.send_cmd(`ACC_OP_START, 15);
        reg_rd(`ACC_OFS_STATUS, rv);
        check(rv, 32'h0000_0010);
        reg_wr(`ACC_OFS_CTRL, 32'h0000_0003);
        u_host.send_cmd(`ACC_OP_START, 16);
        reg_rd(`ACC_OFS_STATUS, rv);
        check(rv, 32'h0000_0010);
        u_host.send_cmd(`ACC_OP_START, 32);
        reg_rd(`ACC_OFS_STATUS, rv);
        check(rv & 32'h17, 32'h0000_0011);
        $display("test command framing done");

        // restart in mid-conversion drops it and restarts timing
        repeat (delay_us * 100 + 200) @(posedge clk);
        reg_rd(`ACC_OFS_STATUS, rv);
        check(rv & 32'h17, 32'h0000_0012);
        reg_wr(`ACC_OFS_CTRL, 32'h0000_0000);
        u_host.send_cmd(`ACC_OP_START, 16);
        t0 = cycles;
        exp_q.push_back((delay_us + period_us + 380) * 100);
        reg_rd(`ACC_OFS_INT_STAT, rv);
        check(rv, 32'h0000_0006);
        check({31'h0, result_ready_n}, 32'h1);
        reg_wr(`ACC_OFS_INT_STAT, 32'h0000_0007);
        wait_ready(1'b0, 60000);
        check_near(cycles - t0, 250);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        $display("test restart latency done");

        // continuous results one period apart; stop lets the running one end
        t0 = cycles;
        exp_q.push_back(800);
        exp_q.push_back(period_us * 100);
        wait_ready(1'b1, 3000);
        check_near(cycles - t0, 150);
        u_host.send_cmd(`ACC_OP_STOP, 16);
        wait_ready(1'b0, 3000);
        check_near(cycles - t0, 150);
        repeat (period_us * 200) @(posedge clk);
        check({31'h0, result_ready_n}, 32'h0);
        reg_rd(`ACC_OFS_STATUS, rv);
        check(rv & 32'h17, 32'h0000_0000);
        reg_wr(`ACC_OFS_INT_STAT, 32'h0000_0007);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        $display("test continuous stop done");

        // pulse mode from the pin, fir filter, pin dropped mid-conversion
        reg_wr(`ACC_OFS_INT_MASK, 32'h0000_0000);
        reg_wr(`ACC_OFS_MODE, 32'h0000_0014);
        u_host.set_start(1'b1);
        t0 = cycles;
        exp_q.push_back((delay_us + period_us + 380) * 100);
        repeat (8) @(posedge clk);
        check({31'h0, result_ready_n}, 32'h1);
        repeat (delay_us * 100 + 300) @(posedge clk);
        u_host.set_start(1'b0);
        wait_ready(1'b0, 60000);
        check_near(cycles - t0, 250);
        repeat (period_us * 300) @(posedge clk);
        check({31'h0, result_ready_n}, 32'h0);
        check({31'h0, irq}, 32'h0);
        reg_rd(`ACC_OFS_STATUS, rv);
        check(rv & 32'h17, 32'h0000_0000);
        reg_rd(`ACC_OFS_INT_STAT, rv);
        check(rv, 32'h0000_0001);
        $display("test pulse pin done");
        close_out();
    end
endmodule : adc_conversion_control_tb
